// File: hdl/mdt_params.svh
// Constants of the metering threshold bank: word indices, fields, values.
`ifndef MDT_PARAMS_SVH
`define MDT_PARAMS_SVH

`define MDT_IDX_BASE       16'h43A3
`define MDT_IDX_A_GAIN     16'h43A3
`define MDT_IDX_A_OFFSET   16'h43A4
`define MDT_IDX_B_GAIN     16'h43A5
`define MDT_IDX_B_OFFSET   16'h43A6
`define MDT_IDX_C_GAIN     16'h43A7
`define MDT_IDX_C_OFFSET   16'h43A8
`define MDT_IDX_APP_HI     16'h43A9
`define MDT_IDX_APP_LO     16'h43AA
`define MDT_IDX_ACT_HI     16'h43AB
`define MDT_IDX_ACT_LO     16'h43AC
`define MDT_IDX_REA_HI     16'h43AD
`define MDT_IDX_REA_LO     16'h43AE
`define MDT_IDX_RSVD_A     16'h43AF
`define MDT_IDX_APP_NOLOAD 16'h43B0
`define MDT_IDX_ACT_NOLOAD 16'h43B1
`define MDT_IDX_REA_NOLOAD 16'h43B2
`define MDT_IDX_VOLT_LVL   16'h43B3
`define MDT_IDX_RSVD_NW    16'h43B4
`define MDT_IDX_INT_COEFF  16'h43B5
`define MDT_IDX_HPF_DIS    16'h43B6
`define MDT_IDX_RSVD_B     16'h43B7
`define MDT_IDX_SUM_LEVEL  16'h43B8
`define MDT_IDX_LAST       16'h43B8
`define MDT_IDX_STATUS     16'h4300
`define MDT_WORD_COUNT     22
`define MDT_WORD_RESET     24'h00_0000
`define MDT_COEFF_ON       24'hFF_8000
`define MDT_STAT_MISMATCH  0
`define MDT_STAT_COEFF_OK  1
`define MDT_STAT_INTEG_ON  2

`endif

// File: hdl/mdt_pkg.sv
// Types shared by the metering threshold bank.
package mdt_pkg;

	typedef logic [23:0] mdt_word_t;

	typedef enum logic [1:0] {
		MDT_IDLE,
		MDT_RD_FETCH,
		MDT_RD_RESP,
		MDT_WR_RESP
	} mdt_bus_state_t;

	typedef struct packed {
		logic [47:0] apparent;
		logic [47:0] active;
		logic [47:0] reactive;
	} mdt_thresholds_t;

	typedef struct packed {
		mdt_word_t apparent;
		mdt_word_t active;
		mdt_word_t reactive;
	} mdt_noload_t;

	typedef struct packed {
		mdt_word_t gain;
		mdt_word_t offset;
	} mdt_phase_corr_t;

	typedef struct packed {
		mdt_phase_corr_t phaseA;
		mdt_phase_corr_t phaseB;
		mdt_phase_corr_t phaseC;
	} mdt_fund_corr_t;

	typedef struct packed {
		mdt_word_t fundVoltageLevel;
		mdt_word_t integratorCoeff;
		mdt_word_t highpassDisable;
		mdt_word_t sumMismatchLevel;
	} mdt_misc_t;

	typedef struct packed {
		mdt_bus_state_t state;
		logic           waitReq;
		logic [31:0]    readData;
		logic           mismatch;
		logic           coeffOk;
	} mdt_bank_state_t;

endpackage : mdt_pkg

// File: hdl/mdt_word_mem.sv
// Small word memory with byte-lane writes and a registered read port.
`timescale 1ns/10ps
`default_nettype none

module mdt_word_mem #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 22,
	parameter int AW    = 5
) (
	input  wire logic                        core_clk,
	input  wire logic                        nrst,
	input  wire logic                        wrEn,
	input  wire logic [AW-1:0]               wrAddr,
	input  wire logic [WIDTH-1:0]            wrData,
	input  wire logic [WIDTH/8-1:0]          wrByteEn,
	input  wire logic                        rdEn,
	input  wire logic [AW-1:0]               rdAddr,
	output logic      [WIDTH-1:0]            rdData,
	output logic      [DEPTH-1:0][WIDTH-1:0] allWords
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0]            rdData;
	} mdt_mem_state_t;

	mdt_mem_state_t q;
	mdt_mem_state_t d;

	// Out-of-range addresses do not write, and an out-of-range read loads zero into the read register.
	always_comb begin
		d = q;
		if (wrEn && (32'(wrAddr) < DEPTH)) begin
			for (int b = 0; b < WIDTH / 8; b++) begin
				if (wrByteEn[b]) begin
					d.words[wrAddr][b*8 +: 8] = wrData[b*8 +: 8];
				end
			end
		end
		if (rdEn) begin
			d.rdData = (32'(rdAddr) < DEPTH) ? q.words[rdAddr] : '0;
		end
	end

	// Every word clears on reset, which is the documented default.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdData   = q.rdData;
	assign allWords = q.words;

endmodule : mdt_word_mem

`default_nettype wire

// File: hdl/mdt_threshold_bank.sv
// Threshold and calibration word bank with an Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "mdt_params.svh"

module mdt_threshold_bank #(
	parameter int ADDR_W = 18,
	parameter int WORDS  = `MDT_WORD_COUNT
) (
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic [ADDR_W-1:0]      avsAddress,
	input  wire logic                   avsRead,
	input  wire logic                   avsWrite,
	input  wire logic [31:0]            avsWriteData,
	input  wire logic [3:0]             avsByteEnable,
	output logic      [31:0]            avsReadData,
	output logic                        avsWaitRequest,
	input  wire logic                   integratorOn,
	input  wire logic [27:0]            phaseSumSample,
	input  wire logic [23:0]            neutralSample,
	input  wire logic                   sampleValid,
	output logic                        sumMismatch,
	output logic                        integratorCoeffOk,
	output mdt_pkg::mdt_thresholds_t    powerThresholds,
	output mdt_pkg::mdt_noload_t        noloadLevels,
	output mdt_pkg::mdt_fund_corr_t     fundCorrection,
	output mdt_pkg::mdt_misc_t          miscSettings
);

	localparam int OFS_W = $clog2(WORDS);

	localparam mdt_pkg::mdt_bank_state_t RESET_STATE = '{
		state:    mdt_pkg::MDT_IDLE,
		waitReq:  1'b1,
		readData: 32'h0000_0000,
		mismatch: 1'b0,
		coeffOk:  1'b0
	};

	mdt_pkg::mdt_bank_state_t               q;
	mdt_pkg::mdt_bank_state_t               d;
	logic                                   memRdEn;
	logic                                   memWrEn;
	logic [OFS_W-1:0]                       memSlot;
	mdt_pkg::mdt_word_t                     memRdData;
	logic [WORDS-1:0][23:0]                 memWords;
	logic [15:0]                            reqIdx;
	logic                                   reqHit;
	logic [31:0]                            statusWord;
	logic signed [29:0]                     diffWide;
	logic signed [29:0]                     absWide;
	logic signed [29:0]                     levelWide;
	logic                                   overLevel;

	// Word index of a byte address; each word sits on its own aligned word.
	function automatic logic [15:0] wordIndex(input logic [ADDR_W-1:0] a);
		return 16'(a >> 2);
	endfunction : wordIndex

	// True for any index inside the bank, reserved words included.
	function automatic logic inBank(input logic [15:0] idx);
		return (idx >= `MDT_IDX_BASE) && (idx <= `MDT_IDX_LAST);
	endfunction : inBank

	// Reserved words hold no state of their own.
	function automatic logic isReserved(input logic [15:0] idx);
		logic r;
		r = 1'b0;
		if (idx == `MDT_IDX_RSVD_A) begin
			r = 1'b1;
		end else if (idx == `MDT_IDX_RSVD_B) begin
			r = 1'b1;
		end else if (idx == `MDT_IDX_RSVD_NW) begin
			r = 1'b1;
		end
		return r;
	endfunction : isReserved

	// The threshold halves and the filter-disable word are unsigned.
	function automatic logic isSigned(input logic [15:0] idx);
		logic s;
		s = 1'b1;
		if ((idx >= `MDT_IDX_APP_HI) && (idx <= `MDT_IDX_REA_LO)) begin
			s = 1'b0;
		end else if (idx == `MDT_IDX_HPF_DIS) begin
			s = 1'b0;
		end
		return s;
	endfunction : isSigned

	// Memory slot of an index inside the bank.
	function automatic logic [OFS_W-1:0] slot(input logic [15:0] idx);
		return OFS_W'(idx - `MDT_IDX_BASE);
	endfunction : slot

	// Read word: signed values sign-extend through bit 27, unsigned pad.
	function automatic logic [31:0] formatRead(
		input logic [15:0]        idx,
		input mdt_pkg::mdt_word_t w,
		input logic [31:0]        status
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (idx == `MDT_IDX_STATUS) begin
			r = status;
		end else if (!inBank(idx) || isReserved(idx)) begin
			r = 32'h0000_0000;
		end else if (isSigned(idx)) begin
			r = {4'h0, {4{w[23]}}, w};
		end else begin
			r = {8'h00, w};
		end
		return r;
	endfunction : formatRead

	// A misaligned byte address decodes to nothing and reads as zero.
	assign reqIdx  = wordIndex(avsAddress);
	assign reqHit  = (avsAddress[1:0] == 2'b00) && inBank(reqIdx);
	assign memSlot = slot(reqIdx);

	// Status word shows the comparator and the coefficient check.
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`MDT_STAT_MISMATCH] = q.mismatch;
		statusWord[`MDT_STAT_COEFF_OK] = q.coeffOk;
		statusWord[`MDT_STAT_INTEG_ON] = integratorOn;
	end

	// Two's complement difference, widened so that no overflow can occur.
	always_comb begin
		diffWide  = $signed({{2{phaseSumSample[27]}}, phaseSumSample}) -
			$signed({{6{neutralSample[23]}}, neutralSample});
		absWide   = diffWide[29] ? -diffWide : diffWide;
		levelWide = $signed({{6{miscSettings.sumMismatchLevel[23]}},
			miscSettings.sumMismatchLevel});
		overLevel = absWide > levelWide;
	end

	// Bus sequencer: reads take three cycles, writes two, one at a time.
	always_comb begin
		d       = q;
		memRdEn = 1'b0;
		memWrEn = 1'b0;
		case (q.state)
			mdt_pkg::MDT_IDLE: begin
				d.waitReq = 1'b1;
				if (avsRead) begin
					memRdEn = reqHit;
					d.state = mdt_pkg::MDT_RD_FETCH;
				end else if (avsWrite) begin
					d.waitReq = 1'b0;
					d.state   = mdt_pkg::MDT_WR_RESP;
				end
			end
			mdt_pkg::MDT_RD_FETCH: begin
				// A misaligned address reads zero, the status word included.
				d.readData = 32'h0000_0000;
				if (avsAddress[1:0] == 2'b00) begin
					d.readData = formatRead(reqIdx, memRdData, statusWord);
				end
				d.waitReq  = 1'b0;
				d.state    = mdt_pkg::MDT_RD_RESP;
			end
			mdt_pkg::MDT_RD_RESP: begin
				d.waitReq = 1'b1;
				d.state   = mdt_pkg::MDT_IDLE;
			end
			mdt_pkg::MDT_WR_RESP: begin
				// Reserved words drop writes, so they always stay zero.
				memWrEn   = reqHit && !isReserved(reqIdx);
				d.waitReq = 1'b1;
				d.state   = mdt_pkg::MDT_IDLE;
			end
			default: begin
				d.waitReq = 1'b1;
				d.state   = mdt_pkg::MDT_IDLE;
			end
		endcase
		// The flag follows each sample; it holds between samples.
		if (sampleValid) begin
			d.mismatch = overLevel;
		end
		// Without the expected coefficient integrated samples are unusable.
		d.coeffOk = !integratorOn ||
			(miscSettings.integratorCoeff == `MDT_COEFF_ON);
	end

	// The whole control state is one register.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// Only the low three lanes carry data; lane 3 is the padding byte.
	mdt_word_mem #(
		.WIDTH (24),
		.DEPTH (WORDS),
		.AW    (OFS_W)
	) u_words (
		.core_clk (core_clk),
		.nrst     (nrst),
		.wrEn     (memWrEn),
		.wrAddr   (memSlot),
		.wrData   (avsWriteData[23:0]),
		.wrByteEn (avsByteEnable[2:0]),
		.rdEn     (memRdEn),
		.rdAddr   (memSlot),
		.rdData   (memRdData),
		.allWords (memWords)
	);

	// Bus outputs come straight from the state register.
	assign avsReadData       = q.readData;
	assign avsWaitRequest    = q.waitReq;
	assign sumMismatch       = q.mismatch;
	assign integratorCoeffOk = q.coeffOk;

	// Thresholds are wide joins of two stored halves.
	assign powerThresholds.apparent = {memWords[slot(`MDT_IDX_APP_HI)],
		memWords[slot(`MDT_IDX_APP_LO)]};
	assign powerThresholds.active   = {memWords[slot(`MDT_IDX_ACT_HI)],
		memWords[slot(`MDT_IDX_ACT_LO)]};
	assign powerThresholds.reactive = {memWords[slot(`MDT_IDX_REA_HI)],
		memWords[slot(`MDT_IDX_REA_LO)]};

	// No-load levels leave as raw signed words.
	assign noloadLevels.apparent = memWords[slot(`MDT_IDX_APP_NOLOAD)];
	assign noloadLevels.active   = memWords[slot(`MDT_IDX_ACT_NOLOAD)];
	assign noloadLevels.reactive = memWords[slot(`MDT_IDX_REA_NOLOAD)];

	// Per-phase fundamental reactive corrections.
	assign fundCorrection.phaseA.gain   = memWords[slot(`MDT_IDX_A_GAIN)];
	assign fundCorrection.phaseA.offset = memWords[slot(`MDT_IDX_A_OFFSET)];
	assign fundCorrection.phaseB.gain   = memWords[slot(`MDT_IDX_B_GAIN)];
	assign fundCorrection.phaseB.offset = memWords[slot(`MDT_IDX_B_OFFSET)];
	assign fundCorrection.phaseC.gain   = memWords[slot(`MDT_IDX_C_GAIN)];
	assign fundCorrection.phaseC.offset = memWords[slot(`MDT_IDX_C_OFFSET)];

	// Remaining settings for the current and fundamental datapaths.
	assign miscSettings.fundVoltageLevel = memWords[slot(`MDT_IDX_VOLT_LVL)];
	assign miscSettings.integratorCoeff  = memWords[slot(`MDT_IDX_INT_COEFF)];
	assign miscSettings.highpassDisable  = memWords[slot(`MDT_IDX_HPF_DIS)];
	assign miscSettings.sumMismatchLevel = memWords[slot(`MDT_IDX_SUM_LEVEL)];

	// Checks of the design against its own behaviour.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	logic fullWrite;
	assign fullWrite = (q.state == mdt_pkg::MDT_WR_RESP) && avsWrite &&
		(avsAddress[1:0] == 2'b00) && (avsByteEnable[2:0] == 3'b111);

	property p_apparent_high;
		fullWrite && (reqIdx == `MDT_IDX_APP_HI) |=>
			powerThresholds.apparent[47:24] == $past(avsWriteData[23:0]);
	endproperty
	a_apparent_high: assert property (p_apparent_high)
		else $error("apparent threshold high half not updated");

	property p_active_low;
		fullWrite && (reqIdx == `MDT_IDX_ACT_LO) |=>
			powerThresholds.active[23:0] == $past(avsWriteData[23:0]);
	endproperty
	a_active_low: assert property (p_active_low)
		else $error("active threshold low half not updated");

	property p_reactive_high;
		fullWrite && (reqIdx == `MDT_IDX_REA_HI) |=>
			powerThresholds.reactive[47:24] == $past(avsWriteData[23:0]);
	endproperty
	a_reactive_high: assert property (p_reactive_high)
		else $error("reactive threshold high half not updated");

	property p_noload_write;
		fullWrite && (reqIdx == `MDT_IDX_REA_NOLOAD) |=>
			noloadLevels.reactive == $past(avsWriteData[23:0]);
	endproperty
	a_noload_write: assert property (p_noload_write)
		else $error("reactive no-load level not updated");

	property p_coeff_ok;
		fullWrite && (reqIdx == `MDT_IDX_INT_COEFF) &&
			(avsWriteData == 32'h0FFF_8000) |-> ##2 integratorCoeffOk;
	endproperty
	a_coeff_ok: assert property (p_coeff_ok)
		else $error("integrator coefficient not accepted");

	property p_highpass;
		fullWrite && (reqIdx == `MDT_IDX_HPF_DIS) |=>
			miscSettings.highpassDisable == $past(avsWriteData[23:0]);
	endproperty
	a_highpass: assert property (p_highpass)
		else $error("high-pass disable word not updated");

	property p_mismatch;
		sampleValid |=> sumMismatch == $past(overLevel);
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("current sum mismatch flag wrong");

	property p_reserved_zero;
		(q.state == mdt_pkg::MDT_WR_RESP) && isReserved(reqIdx) |=>
			memWords[slot(`MDT_IDX_RSVD_A)] == 24'h00_0000 &&
			memWords[slot(`MDT_IDX_RSVD_B)] == 24'h00_0000 &&
			memWords[slot(`MDT_IDX_RSVD_NW)] == 24'h00_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved word changed by a write");

	property p_gain_b;
		fullWrite && (reqIdx == `MDT_IDX_B_GAIN) |=>
			fundCorrection.phaseB.gain == $past(avsWriteData[23:0]);
	endproperty
	a_gain_b: assert property (p_gain_b)
		else $error("phase B gain word not updated");

	property p_offset_c;
		fullWrite && (reqIdx == `MDT_IDX_C_OFFSET) |=>
			fundCorrection.phaseC.offset == $past(avsWriteData[23:0]);
	endproperty
	a_offset_c: assert property (p_offset_c)
		else $error("phase C offset word not updated");

	property p_signed_read;
		(q.state == mdt_pkg::MDT_RD_RESP) && reqHit && isSigned(reqIdx) |->
			avsReadData[31:28] == 4'h0 &&
			avsReadData[27:24] == {4{avsReadData[23]}};
	endproperty
	a_signed_read: assert property (p_signed_read)
		else $error("signed read word badly extended");

	property p_unsigned_read;
		(q.state == mdt_pkg::MDT_RD_RESP) && !isSigned(reqIdx) |->
			avsReadData[31:24] == 8'h00;
	endproperty
	a_unsigned_read: assert property (p_unsigned_read)
		else $error("unsigned read word badly padded");

	property p_read_timing;
		(q.state == mdt_pkg::MDT_IDLE) && avsRead |->
			avsWaitRequest[*2] ##1 !avsWaitRequest ##1 avsWaitRequest;
	endproperty
	a_read_timing: assert property (p_read_timing)
		else $error("read answer not on the third cycle");

	c_read: cover property ((q.state == mdt_pkg::MDT_RD_RESP) && reqHit);
	c_write: cover property (fullWrite && reqHit);
	c_mismatch: cover property ($rose(sumMismatch));
	c_coeff: cover property (integratorOn && $rose(integratorCoeffOk));

endmodule : mdt_threshold_bank

`default_nettype wire

// File: sim/mdt_host_model.sv
// Host-side model that masters the Avalon-MM register port of the bank.
`timescale 1ns/10ps
`default_nettype none
`include "mdt_params.svh"

module mdt_host_model (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	output logic      [17:0] avsAddress,
	output logic             avsRead,
	output logic             avsWrite,
	output logic      [31:0] avsWriteData,
	output logic      [3:0]  avsByteEnable,
	input  wire logic [31:0] avsReadData,
	input  wire logic        avsWaitRequest
);
	localparam int WAIT_LIMIT = 64;

	// The bus is idle from time zero; nothing is requested during reset.
	initial begin
		avsAddress    = 18'h3_FFFF;
		avsRead       = 1'b0;
		avsWrite      = 1'b0;
		avsWriteData  = 32'hFFFF_FFFF;
		avsByteEnable = 4'h0;
	end

	// One transfer, held whole until waitrequest is sampled low or WAIT_LIMIT cycles pass.
	task automatic busCycle(input logic wr, input logic [17:0] addr,
		input logic [31:0] wdata, input logic [3:0] be,
		output logic [31:0] rdata, output logic ok);
		int n;
		ok = 1'b0;
		rdata = 32'h0000_0000;
		@(posedge core_clk);
		avsAddress    <= addr;
		avsWriteData  <= wdata;
		avsByteEnable <= be;
		avsRead       <= !wr;
		avsWrite      <= wr;
		for (n = 0; n < WAIT_LIMIT && !ok; n++) begin
			@(posedge core_clk);
			if (avsWaitRequest === 1'b0) begin
				ok = 1'b1;
				rdata = avsReadData;
			end
		end
		// Released address, data and byte-enable lines carry the inverse, so a stale value never passes.
		avsRead       <= 1'b0;
		avsWrite      <= 1'b0;
		avsAddress    <= ~addr;
		avsWriteData  <= ~wdata;
		avsByteEnable <= ~be;
	endtask : busCycle

	// A write that never touches the no-write reserved word.
	task automatic busWrite(input logic [17:0] addr, input logic [31:0] d,
		input logic [3:0] be, output logic ok);
		logic [31:0] unused;
		ok = 1'b1;
		if (addr[17:2] != `MDT_IDX_RSVD_NW) begin
			busCycle(1'b1, addr, d, be, unused, ok);
		end
	endtask : busWrite

	task automatic busRead(input logic [17:0] addr, output logic [31:0] d,
		output logic ok);
		busCycle(1'b0, addr, 32'h0000_0000, 4'hF, d, ok);
	endtask : busRead

	// The coefficient goes out in its sign-extended transfer form.
	task automatic loadCoeff(output logic ok);
		busWrite({`MDT_IDX_INT_COEFF, 2'b00}, 32'h0FFF_8000, 4'hF, ok);
	endtask : loadCoeff

	// Keep-zero words are only ever given zero.
	task automatic keepReservedZero(output logic ok);
		logic okA;
		busWrite({`MDT_IDX_RSVD_A, 2'b00}, 32'h0000_0000, 4'hF, okA);
		busWrite({`MDT_IDX_RSVD_B, 2'b00}, 32'h0000_0000, 4'hF, ok);
		ok = ok & okA;
	endtask : keepReservedZero
endmodule : mdt_host_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the metering threshold bank.
`timescale 1ns/10ps
`default_nettype none
`include "mdt_params.svh"

module tb_top;
	logic                     core_clk;
	logic                     nrst;
	logic [17:0]              avsAddress;
	logic                     avsRead;
	logic                     avsWrite;
	logic [31:0]              avsWriteData;
	logic [3:0]               avsByteEnable;
	logic [31:0]              avsReadData;
	logic                     avsWaitRequest;
	logic                     integratorOn;
	logic [27:0]              phaseSumSample;
	logic [23:0]              neutralSample;
	logic                     sampleValid;
	logic                     sumMismatch;
	logic                     integratorCoeffOk;
	mdt_pkg::mdt_thresholds_t powerThresholds;
	mdt_pkg::mdt_noload_t     noloadLevels;
	mdt_pkg::mdt_fund_corr_t  fundCorrection;
	mdt_pkg::mdt_misc_t       miscSettings;
	int                       errCount;
	int                       comparisons;

	mdt_threshold_bank dut_u (.core_clk(core_clk), .nrst(nrst),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.integratorOn(integratorOn), .phaseSumSample(phaseSumSample),
		.neutralSample(neutralSample), .sampleValid(sampleValid),
		.sumMismatch(sumMismatch), .integratorCoeffOk(integratorCoeffOk),
		.powerThresholds(powerThresholds), .noloadLevels(noloadLevels),
		.fundCorrection(fundCorrection), .miscSettings(miscSettings));

	mdt_host_model host_u (.core_clk(core_clk), .nrst(nrst),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

	// Free-running core clock, 10 ns period.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("BAD %0t got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask : chk

	// A bus answer that never comes ends the run at once.
	task automatic stall();
		errCount++;
		$display("BAD %0t no answer 0x%h 0x%h", $time, avsAddress, 1'b0);
		wrap_up();
	endtask : stall

	task automatic wr(input logic [15:0] idx, input logic [31:0] d,
		input logic [3:0] be);
		logic ok;
		host_u.busWrite({idx, 2'b00}, d, be, ok);
		if (ok !== 1'b1) stall();
	endtask : wr

	task automatic rdChk(input logic [17:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		logic        ok;
		host_u.busRead(addr, d, ok);
		if (ok !== 1'b1) stall();
		chk({16'h0000, d}, {16'h0000, exp});
	endtask : rdChk

	function automatic logic [23:0] pat(input logic [15:0] idx);
		return {idx[0] ? 4'h8 : 4'h1, idx[3:0], 16'h5A0F};
	endfunction : pat

	// Where each stored word shows on the output structs.
	function automatic logic [23:0] fieldOf(input logic [15:0] idx);
		case (idx)
			`MDT_IDX_A_GAIN:     return fundCorrection.phaseA.gain;
			`MDT_IDX_A_OFFSET:   return fundCorrection.phaseA.offset;
			`MDT_IDX_B_GAIN:     return fundCorrection.phaseB.gain;
			`MDT_IDX_B_OFFSET:   return fundCorrection.phaseB.offset;
			`MDT_IDX_C_GAIN:     return fundCorrection.phaseC.gain;
			`MDT_IDX_C_OFFSET:   return fundCorrection.phaseC.offset;
			`MDT_IDX_APP_HI:     return powerThresholds.apparent[47:24];
			`MDT_IDX_APP_LO:     return powerThresholds.apparent[23:0];
			`MDT_IDX_ACT_HI:     return powerThresholds.active[47:24];
			`MDT_IDX_ACT_LO:     return powerThresholds.active[23:0];
			`MDT_IDX_REA_HI:     return powerThresholds.reactive[47:24];
			`MDT_IDX_REA_LO:     return powerThresholds.reactive[23:0];
			`MDT_IDX_APP_NOLOAD: return noloadLevels.apparent;
			`MDT_IDX_ACT_NOLOAD: return noloadLevels.active;
			`MDT_IDX_REA_NOLOAD: return noloadLevels.reactive;
			`MDT_IDX_VOLT_LVL:   return miscSettings.fundVoltageLevel;
			`MDT_IDX_INT_COEFF:  return miscSettings.integratorCoeff;
			`MDT_IDX_HPF_DIS:    return miscSettings.highpassDisable;
			`MDT_IDX_SUM_LEVEL:  return miscSettings.sumMismatchLevel;
			default:             return 24'h00_0000;
		endcase
	endfunction : fieldOf

	// Garbage in the top byte must be dropped; reads pad by signedness.
	task automatic wordCheck(input logic [15:0] idx, input logic isSigned);
		logic [23:0] w;
		w = pat(idx);
		wr(idx, {8'hC3, w}, 4'hF);
		@(posedge core_clk);
		#1;
		chk({24'h00_0000, fieldOf(idx)}, {24'h00_0000, w});
		if (isSigned) rdChk({idx, 2'b00}, {4'h0, {4{w[23]}}, w});
		else rdChk({idx, 2'b00}, {8'h00, w});
	endtask : wordCheck

	// One comparator sample, held a single cycle, then the flag is read.
	task automatic sample(input logic [27:0] ps, input logic [23:0] nt,
		input logic exp);
		@(posedge core_clk);
		phaseSumSample <= ps;
		neutralSample  <= nt;
		sampleValid    <= 1'b1;
		@(posedge core_clk);
		sampleValid <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({47'h0, sumMismatch}, {47'h0, exp});
	endtask : sample

	// All bank words read zero out of reset, and so do the checked outputs; the status word reads 2.
	task automatic t_reset();
		logic [15:0] i;
		for (i = `MDT_IDX_BASE; i <= `MDT_IDX_LAST; i++) begin
			rdChk({i, 2'b00}, 32'h0000_0000);
		end
		chk(powerThresholds.apparent, 48'h0000_0000_0000);
		chk(fundCorrection.phaseA, 48'h0000_0000_0000);
		chk({24'h00_0000, noloadLevels.apparent}, 48'h0000_0000_0000);
		rdChk({`MDT_IDX_STATUS, 2'b00}, 32'h0000_0002);
	endtask : t_reset

	task automatic t_words();
		logic [15:0] sIdx [12];
		logic [15:0] uIdx [7];
		sIdx = '{`MDT_IDX_A_GAIN, `MDT_IDX_A_OFFSET, `MDT_IDX_B_GAIN,
			`MDT_IDX_B_OFFSET, `MDT_IDX_C_GAIN, `MDT_IDX_C_OFFSET,
			`MDT_IDX_APP_NOLOAD, `MDT_IDX_ACT_NOLOAD, `MDT_IDX_REA_NOLOAD,
			`MDT_IDX_VOLT_LVL, `MDT_IDX_INT_COEFF, `MDT_IDX_SUM_LEVEL};
		uIdx = '{`MDT_IDX_APP_HI, `MDT_IDX_APP_LO, `MDT_IDX_ACT_HI,
			`MDT_IDX_ACT_LO, `MDT_IDX_REA_HI, `MDT_IDX_REA_LO,
			`MDT_IDX_HPF_DIS};
		foreach (sIdx[k]) wordCheck(sIdx[k], 1'b1);
		foreach (uIdx[k]) wordCheck(uIdx[k], 1'b0);
		chk(powerThresholds.apparent, {pat(16'h43A9), pat(16'h43AA)});
		chk(powerThresholds.active, {pat(16'h43AB), pat(16'h43AC)});
		chk(powerThresholds.reactive, {pat(16'h43AD), pat(16'h43AE)});
		// Lane 1 alone clears only the middle byte.
		wr(`MDT_IDX_APP_LO, 32'h00FF_FFFF, 4'hF);
		wr(`MDT_IDX_APP_LO, 32'h0000_0000, 4'b0010);
		rdChk({`MDT_IDX_APP_LO, 2'b00}, 32'h00FF_00FF);
	endtask : t_words

	// Reserved, unmapped and misaligned places answer zero.
	task automatic t_reserved();
		logic ok;
		host_u.keepReservedZero(ok);
		if (ok !== 1'b1) stall();
		rdChk({`MDT_IDX_RSVD_A, 2'b00}, 32'h0000_0000);
		rdChk({`MDT_IDX_RSVD_NW, 2'b00}, 32'h0000_0000);
		rdChk({`MDT_IDX_RSVD_B, 2'b00}, 32'h0000_0000);
		wr(16'h43A2, 32'h0012_3456, 4'hF);
		rdChk({16'h43A2, 2'b00}, 32'h0000_0000);
		// The neighbour word must not have caught the unmapped write.
		chk({24'h00_0000, fundCorrection.phaseA.gain},
			{24'h00_0000, pat(16'h43A3)});
		// A nonzero read first, so a stale answer would show.
		rdChk({`MDT_IDX_APP_HI, 2'b00}, {8'h00, pat(16'h43A9)});
		rdChk({`MDT_IDX_APP_HI, 2'b01}, 32'h0000_0000);
	endtask : t_reserved

	// Absolute difference against the signed level, strictly greater.
	task automatic t_mismatch();
		wr(`MDT_IDX_SUM_LEVEL, 32'h0000_0064, 4'hF);
		sample(28'd300, 24'd100, 1'b1);
		sample(28'hFFF_FFCE, 24'd40, 1'b0);
		sample(28'd150, 24'd50, 1'b0);
		sample(28'd50, 24'hFF_FF9B, 1'b1);
		wr(`MDT_IDX_SUM_LEVEL, 32'h0FFF_FFFF, 4'hF);
		sample(28'd7, 24'd7, 1'b1);
	endtask : t_mismatch

	task automatic t_coeff();
		logic ok;
		@(posedge core_clk);
		integratorOn <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk({47'h0, integratorCoeffOk}, 48'h0);
		host_u.loadCoeff(ok);
		if (ok !== 1'b1) stall();
		repeat (2) @(posedge core_clk);
		#1;
		chk({47'h0, integratorCoeffOk}, 48'h1);
		chk({24'h0, miscSettings.integratorCoeff}, 48'hFF_8000);
		rdChk({`MDT_IDX_INT_COEFF, 2'b00}, 32'h0FFF_8000);
		rdChk({`MDT_IDX_STATUS, 2'b00}, 32'h0000_0007);
	endtask : t_coeff

	// A second reset in mid-run clears every stored word.
	task automatic t_rereset();
		@(posedge core_clk);
		nrst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(powerThresholds.reactive, 48'h0);
		chk({24'h0, miscSettings.integratorCoeff}, 48'h0);
		@(posedge core_clk);
		nrst <= 1'b1;
		rdChk({`MDT_IDX_C_GAIN, 2'b00}, 32'h0000_0000);
	endtask : t_rereset

	// Main sequence: reset for two cycles, then each scenario in turn.
	initial begin
		errCount       = 0;
		comparisons    = 0;
		nrst           = 1'b0;
		integratorOn   = 1'b0;
		phaseSumSample = 28'h000_0000;
		neutralSample  = 24'h00_0000;
		sampleValid    = 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_words();
		t_reserved();
		t_mismatch();
		t_coeff();
		t_rereset();
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
